// file: pkg/ltc_pkg.sv
// Shared constants and carrier types for the transceiver mode and wake control
// Assumes one 100 MHz core clock and no register bus
`default_nettype none

package ltc_pkg;

  // Core clock rate
  localparam int CLK_MHZ = 100;

  // Bus wake filter, least dominant time
  localparam int WAKE_FILT_US  = 30;
  localparam int WAKE_FILT_CYC = WAKE_FILT_US * CLK_MHZ;

  // Enabling time after entering normal mode
  localparam int EN_TIME_US  = 10;
  localparam int EN_TIME_CYC = EN_TIME_US * CLK_MHZ;

  // Transmit and bus dominant time-outs
  localparam int TXD_TO_US  = 6000;
  localparam int TXD_TO_CYC = TXD_TO_US * CLK_MHZ;
  localparam int BUS_TO_US  = 6000;
  localparam int BUS_TO_CYC = BUS_TO_US * CLK_MHZ;

  // Timer width and event queue depth
  localparam int TMR_W     = 20;
  localparam int EVT_DEPTH = 8;

  // Transceiver mode field encodings
  typedef enum logic [1:0] {
    MODE_OFF  = 2'h0,
    MODE_WAKE = 2'h1,
    MODE_RXO  = 2'h2,
    MODE_NORM = 2'h3
  } ltc_mode_t;

  // System modes, one-hot
  typedef enum logic [4:0] {
    SYS_NORMAL   = 5'h01,
    SYS_STOP     = 5'h02,
    SYS_SLEEP    = 5'h04,
    SYS_RESTART  = 5'h08,
    SYS_FAILSAFE = 5'h10
  } ltc_sys_t;

  // Shared slope settings
  typedef struct packed {
    logic flash_bypass;
    logic low_slope;
  } ltc_cfg_t;

  localparam ltc_cfg_t CFG_RST = '{flash_bypass: 1'h0, low_slope: 1'h0};

  // Wake event record
  typedef struct packed {
    logic [1:0] chan;
    ltc_sys_t   sys;
  } ltc_evt_t;

endpackage

`default_nettype wire

// file: core/ltc_tmr.sv
// Saturating dwell timer: counts while run is high, clears when it drops
// Assumes synchronous run input and asynchronous active-high reset
`default_nettype none

module ltc_tmr #(
  parameter int W     = 20,
  parameter int LIMIT = 3000
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      done
);

  logic [W-1:0] cnt;

  if (LIMIT < 1 || LIMIT >= (2 ** W)) begin : g_chk
    $error("Timer limit does not fit the counter");
  end

  // Count dwell cycles, hold at the limit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (!run) begin
      cnt <= '0;
    end else if (cnt != W'(LIMIT)) begin
      cnt <= cnt + 1'h1;
    end
  end

  // Stays high one cycle past run so an ending edge can still see it
  assign done = (cnt == W'(LIMIT));

endmodule

`default_nettype wire

// file: core/ltc_fifo.sv
// Shift-register FIFO; head word and valid come straight from flip-flops
// Assumes one clock; pop and push may fall in the same cycle
`default_nettype none

module ltc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0]     mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [DEPTH-1:0] shv;
  logic [DEPTH-1:0] wsel;
  logic             pop;
  logic             push;

  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("FIFO needs at least two slots");
  end

  assign pop       = vld[0] & out_ready;
  assign push      = in_valid & in_ready;
  assign in_ready  = ~vld[DEPTH-1];
  assign out_valid = vld[0];
  assign out_data  = mem[0];

  // Occupancy after the shift, and the first free slot
  assign shv  = pop ? (vld >> 1) : vld;
  assign wsel = push ? (~shv & {shv[DEPTH-2:0], 1'h1}) : '0;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vld <= '0;
    end else begin
      vld <= shv | wsel;
    end
  end

  // Storage shifts toward the head on pop
  always_ff @(posedge core_clk) begin
    for (int k = 0; k < DEPTH; k++) begin
      if (wsel[k]) begin
        mem[k] <= in_data;
      end else if (pop) begin
        mem[k] <= mem[(k + 1) % DEPTH];
      end
    end
  end

endmodule

`default_nettype wire

// file: core/ltc_lin_ctl.sv
// Mode, enabling, wake and fault control of two single-wire bus transceivers
// Assumes synchronous inputs, bus_level high = recessive, tx input high = recessive
//
// Function
// - Power-up enters off; off selectable always, silent
// - Off mode ignores bus wake activity entirely
// - Normal mode only in system normal/stop
// - Early dominant suppressed; next fresh dominant sent
// - Receive-only: driver off, receiver on, normal/stop
// - Wake mode by command; forced on fail-safe
// - Wake: falling edge, long dominant, rising edge
// - Wake drives receive low until mode changes
// - Mode field keeps wake encoding after wake
// - Toggling mode away and back re-arms
// - Entering stop, sleep, fail-safe re-arms wake
// - Stop/normal wake: interrupt, status bit, receive low
// - Stop wake enables disabled watchdog when configured
// - Sleep wake: restart, status, no interrupt
// - Restart/fail-safe wake: restart mode, no interrupt
// - Transmit time-out disables driver, sets failure flag
// - Driver returns when transmit leaves dominant
// - Long bus dominant sets failure flag
// - Undervoltage disables driver and receiver, keeps config
// - Default normal slope; low-slope bit changes slope
// - Slope applies at chip select rise; normal only
// - Flash bit bypasses slope, applies at select rise
`default_nettype none

module ltc_lin_ctl #(
  parameter int TXD_TO_CYCLES = ltc_pkg::TXD_TO_CYC,
  parameter int BUS_TO_CYCLES = ltc_pkg::BUS_TO_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire ltc_pkg::ltc_sys_t  sys_mode,
  input  wire logic [1:0]         mode_wr,
  input  wire ltc_pkg::ltc_mode_t mode_wr_data,
  input  wire logic [1:0]         lin_tx_input,
  input  wire logic [1:0]         bus_level,
  input  wire logic               supply_uv,
  input  wire logic [1:0]         fail_clr,
  input  wire logic [1:0]         wake_status_clr,
  input  wire logic               int_clr,
  input  wire logic               watchdog_on_bus_wake,
  input  wire logic               wd_enabled,
  input  wire logic               cfg_wr,
  input  wire ltc_pkg::ltc_cfg_t  cfg_wr_data,
  input  wire logic               spi_chip_select_n,
  input  wire logic               evt_ready,
  output var ltc_pkg::ltc_mode_t  first_transceiver_mode_field,
  output var ltc_pkg::ltc_mode_t  second_transceiver_mode_field,
  output logic                    first_transceiver_failure_flag,
  output logic                    second_transceiver_failure_flag,
  output logic [1:0]              rx_out,
  output logic [1:0]              bus_drive_dom,
  output logic [1:0]              wake_source_status,
  output logic                    int_n,
  output logic                    restart_req,
  output logic                    wd_enable_req,
  output var ltc_pkg::ltc_cfg_t   slope_cfg,
  output logic                    evt_valid,
  output var ltc_pkg::ltc_evt_t   evt_data
);

  import ltc_pkg::*;

  ltc_mode_t  mode_q [2];
  logic [1:0] fail_q;
  logic [1:0] wake_p;
  logic       any_wake;
  ltc_sys_t   sys_prev;
  logic       sys_entry;
  logic       rearm_sys;
  logic       fs_entry;
  logic       run_sys;
  logic       cs_prev;
  ltc_cfg_t   cfg_stage;
  logic [1:0] pend_mask;
  ltc_sys_t   pend_sys;
  logic       fifo_in_ready;
  logic       evt_push;
  ltc_evt_t   evt_in;

  if (TXD_TO_CYCLES < 1 || TXD_TO_CYCLES >= (2 ** TMR_W)) begin : g_chk_tx
    $error("Transmit time-out does not fit the timer");
  end
  if (BUS_TO_CYCLES < 1 || BUS_TO_CYCLES >= (2 ** TMR_W)) begin : g_chk_bus
    $error("Bus time-out does not fit the timer");
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Which modes a command may select in the present system mode
  function automatic logic mode_ok(ltc_mode_t m, ltc_sys_t s);
    logic act_sys;
    act_sys = (s == SYS_NORMAL) || (s == SYS_STOP);
    case (m)
      MODE_OFF:  mode_ok = 1'h1;
      MODE_WAKE: mode_ok = (s != SYS_FAILSAFE);
      default:   mode_ok = act_sys;
    endcase
  endfunction

  assign first_transceiver_mode_field    = mode_q[0];
  assign second_transceiver_mode_field   = mode_q[1];
  assign first_transceiver_failure_flag  = fail_q[0];
  assign second_transceiver_failure_flag = fail_q[1];

  // System mode tracking
  assign sys_entry = (sys_mode != sys_prev);
  assign rearm_sys = sys_entry && (sys_mode == SYS_STOP || sys_mode == SYS_SLEEP ||
                                   sys_mode == SYS_FAILSAFE);
  assign fs_entry  = sys_entry && (sys_mode == SYS_FAILSAFE);
  assign run_sys   = (sys_mode == SYS_NORMAL) || (sys_mode == SYS_STOP);
  assign any_wake  = |wake_p;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_prev <= SYS_NORMAL;
    end else begin
      sys_prev <= sys_mode;
    end
  end

  // Per-transceiver logic
  for (genvar g = 0; g < 2; g++) begin : g_ch
    ltc_mode_t next_mode;
    logic      bus_dom;
    logic      tx_dom;
    logic      bus_prev;
    logic      fall_seen;
    logic      armed;
    logic      woke;
    logic      tx_blk;
    logic      to_blk;
    logic      is_norm;
    logic      is_rxo;
    logic      is_wake;
    logic      rx_act;
    logic      en_done;
    logic      wk_done;
    logic      to_done;
    logic      bus_done;

    assign bus_dom = ~bus_level[g];
    assign tx_dom  = ~lin_tx_input[g];
    assign is_norm = (mode_q[g] == MODE_NORM);
    assign is_rxo  = (mode_q[g] == MODE_RXO);
    assign is_wake = (mode_q[g] == MODE_WAKE);
    assign rx_act  = (is_norm || is_rxo) && !supply_uv;

    // Mode selection; a command wins over the fail-safe entry
    always_comb begin
      next_mode = mode_q[g];
      if (mode_wr[g] && mode_ok(mode_wr_data, sys_mode)) begin
        next_mode = mode_wr_data;
      end else if (fs_entry) begin
        next_mode = MODE_WAKE;
      end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mode_q[g] <= MODE_OFF;
      end else begin
        mode_q[g] <= next_mode;
      end
    end

    ltc_tmr #(.W(TMR_W), .LIMIT(EN_TIME_CYC)) u_en (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .run      (is_norm),
      .done     (en_done)
    );

    ltc_tmr #(.W(TMR_W), .LIMIT(WAKE_FILT_CYC)) u_wk (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .run      (is_wake && armed && fall_seen && bus_dom && !supply_uv),
      .done     (wk_done)
    );

    ltc_tmr #(.W(TMR_W), .LIMIT(TXD_TO_CYCLES)) u_to (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .run      (is_norm && tx_dom),
      .done     (to_done)
    );

    ltc_tmr #(.W(TMR_W), .LIMIT(BUS_TO_CYCLES)) u_bus (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .run      (rx_act && bus_dom),
      .done     (bus_done)
    );

    // Wake fires on the rising edge after a filtered dominant phase
    assign wake_p[g] = is_wake && armed && bus_prev && !bus_dom && wk_done &&
                       !supply_uv;

    // Wake detector state
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        bus_prev  <= 1'h0;
        fall_seen <= 1'h0;
        armed     <= 1'h0;
        woke      <= 1'h0;
      end else begin
        bus_prev  <= bus_dom;
        fall_seen <= bus_dom && (fall_seen || !bus_prev);
        if (wake_p[g]) begin
          armed <= 1'h0;
        end else if ((next_mode == MODE_WAKE && mode_q[g] != MODE_WAKE) || rearm_sys) begin
          armed <= 1'h1;
        end
        woke <= wake_p[g] || (woke && next_mode == MODE_WAKE);
      end
    end

    // Enabling hold-off and transmit time-out
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        tx_blk <= 1'h1;
        to_blk <= 1'h0;
      end else begin
        tx_blk <= !is_norm || (tx_blk && !(en_done && !tx_dom));
        to_blk <= tx_dom && (to_blk || to_done);
      end
    end

    // Failure flag; a new fault wins over the clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        fail_q[g] <= 1'h0;
      end else begin
        fail_q[g] <= to_done || bus_done || (fail_q[g] && !fail_clr[g]);
      end
    end

    // Bus driver and receive output
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        bus_drive_dom[g] <= 1'h0;
        rx_out[g]        <= 1'h1;
      end else begin
        bus_drive_dom[g] <= is_norm && !supply_uv && !tx_blk && !to_blk && tx_dom;
        if (woke || wake_p[g]) begin
          rx_out[g] <= 1'h0;
        end else if (rx_act) begin
          rx_out[g] <= bus_level[g];
        end else begin
          rx_out[g] <= 1'h1;
        end
      end
    end

    a_off_rx_high:
      assert property (mode_q[g] == MODE_OFF |=> rx_out[g])
      else $error("Receive output low in off mode");

    a_rxo_no_drive:
      assert property (mode_q[g] == MODE_RXO |=> !bus_drive_dom[g])
      else $error("Driver active in receive-only mode");

    a_sel_norm_gate:
      assert property ((mode_wr[g] && mode_wr_data == MODE_NORM && !run_sys && !fs_entry)
                       |=> mode_q[g] == $past(mode_q[g]))
      else $error("Normal mode taken outside system normal or stop");

    a_failsafe_wake:
      assert property ((fs_entry && !mode_wr[g]) |=> mode_q[g] == MODE_WAKE)
      else $error("Fail-safe entry did not select wake mode");

    a_wake_rx_low:
      assert property ((wake_p[g] && !mode_wr[g] && !fs_entry)
                       |=> !rx_out[g] && mode_q[g] == MODE_WAKE)
      else $error("Wake did not pull receive output low");

    a_txto_block:
      assert property ((to_done && tx_dom) |=> fail_q[g] ##1 !bus_drive_dom[g])
      else $error("Transmit time-out did not stop the driver");

    a_enable_hold:
      assert property (tx_blk |=> !bus_drive_dom[g])
      else $error("Driver active during enabling hold-off");

    a_uv_quiet:
      assert property (supply_uv |=> !bus_drive_dom[g])
      else $error("Driver active under undervoltage");
  end

  // Wake reporting to the system
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_source_status <= '0;
    end else begin
      wake_source_status <= wake_p | (wake_source_status & ~wake_status_clr);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_n <= 1'h1;
    end else if (any_wake && run_sys) begin
      int_n <= 1'h0;
    end else if (int_clr) begin
      int_n <= 1'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      restart_req   <= 1'h0;
      wd_enable_req <= 1'h0;
    end else begin
      restart_req   <= any_wake && !run_sys;
      wd_enable_req <= any_wake && sys_mode == SYS_STOP && watchdog_on_bus_wake &&
                       !wd_enabled;
    end
  end

  // Slope settings staged in normal mode, applied on chip select rise
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_prev   <= 1'h1;
      cfg_stage <= CFG_RST;
      slope_cfg <= CFG_RST;
    end else begin
      cs_prev <= spi_chip_select_n;
      if (cfg_wr && sys_mode == SYS_NORMAL) begin
        cfg_stage <= cfg_wr_data;
      end
      if (spi_chip_select_n && !cs_prev) begin
        slope_cfg <= cfg_stage;
      end
    end
  end

  // Wake events wait here while the queue is full
  assign evt_push = |pend_mask && fifo_in_ready;
  assign evt_in   = '{chan: pend_mask, sys: pend_sys};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_mask <= '0;
      pend_sys  <= SYS_NORMAL;
    end else begin
      pend_mask <= (evt_push ? 2'h0 : pend_mask) | wake_p;
      if (any_wake) begin
        pend_sys <= sys_mode;
      end
    end
  end

  ltc_fifo #(.W($bits(ltc_evt_t)), .DEPTH(EVT_DEPTH)) u_evt (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (|pend_mask),
    .in_ready  (fifo_in_ready),
    .in_data   (evt_in),
    .out_valid (evt_valid),
    .out_ready (evt_ready),
    .out_data  (evt_data)
  );

  a_stop_wake_int:
    assert property ((any_wake && sys_mode == SYS_STOP)
                     |=> !int_n && ((wake_source_status & $past(wake_p)) == $past(wake_p)))
    else $error("Stop-mode wake missing interrupt or status");

  a_sleep_no_int:
    assert property ((any_wake && sys_mode == SYS_SLEEP && int_n) |=> int_n && restart_req)
    else $error("Sleep wake raised interrupt or skipped restart");

  a_wd_on_wake:
    assert property ((any_wake && sys_mode == SYS_STOP && watchdog_on_bus_wake && !wd_enabled)
                     |=> wd_enable_req)
    else $error("Watchdog enable not requested on stop wake");

  a_slope_cs:
    assert property (!(spi_chip_select_n && !cs_prev) |=> $stable(slope_cfg))
    else $error("Slope settings changed without chip select rise");

  c_wake_seen: cover property (any_wake);
  c_tx_timeout: cover property ($rose(first_transceiver_failure_flag));
  c_slope_change: cover property ($changed(slope_cfg));
  c_queue_full: cover property (!fifo_in_ready);

endmodule

`default_nettype wire

// file: test/ltc_bus_model.sv
// Two single-wire bus lines, one per transceiver, with a remote node on each line
// Assumes a pull-up on each line: a released line reads recessive (1)
`default_nettype none

module ltc_bus_model (
  input  wire logic [1:0] bus_drive_dom,
  input  wire logic [1:0] remote_dom,
  output logic [1:0]      bus_level
);
  timeunit 1ns;
  timeprecision 100ps;

  // Wired-AND: any party pulling dominant wins, else the pull-up gives recessive
  assign bus_level = ~(bus_drive_dom | remote_dom);
endmodule

`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the transceiver mode and wake control
// Assumes ltc_pkg, ltc_fifo, ltc_tmr and ltc_lin_ctl are compiled first
`default_nettype none

module tb;
  import ltc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic       core_clk, sys_rst, supply_uv, int_clr, cfg_wr, evt_ready;
  logic       watchdog_on_bus_wake, wd_enabled, spi_chip_select_n;
  logic [1:0] mode_wr, lin_tx_input, bus_level, remote_dom, fail_clr, wake_status_clr;
  logic [1:0] rx_out, drv, wsrc;
  logic       fail0, fail1, int_n, restart_req, wd_enable_req, evt_valid;
  ltc_sys_t   sys_mode;
  ltc_mode_t  mode_wr_data, mode0, mode1;
  ltc_cfg_t   cfg_wr_data, slope_cfg;
  ltc_evt_t   evt_data;
  int         miscompares, comparisons, n_rst, n_wd, n_pop, nev;

  ltc_lin_ctl #(.TXD_TO_CYCLES(50), .BUS_TO_CYCLES(50)) ltc_lin_ctl_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .sys_mode(sys_mode), .mode_wr(mode_wr),
    .mode_wr_data(mode_wr_data), .lin_tx_input(lin_tx_input), .bus_level(bus_level),
    .supply_uv(supply_uv), .fail_clr(fail_clr), .wake_status_clr(wake_status_clr),
    .int_clr(int_clr), .watchdog_on_bus_wake(watchdog_on_bus_wake),
    .wd_enabled(wd_enabled), .cfg_wr(cfg_wr), .cfg_wr_data(cfg_wr_data),
    .spi_chip_select_n(spi_chip_select_n), .evt_ready(evt_ready),
    .first_transceiver_mode_field(mode0), .second_transceiver_mode_field(mode1),
    .first_transceiver_failure_flag(fail0), .second_transceiver_failure_flag(fail1),
    .rx_out(rx_out), .bus_drive_dom(drv), .wake_source_status(wsrc), .int_n(int_n),
    .restart_req(restart_req), .wd_enable_req(wd_enable_req), .slope_cfg(slope_cfg),
    .evt_valid(evt_valid), .evt_data(evt_data));

  ltc_bus_model ltc_bus_model_i (
    .bus_drive_dom(drv), .remote_dom(remote_dom), .bus_level(bus_level));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Pulse and pop counters
  always @(posedge core_clk) begin
    if (restart_req === 1'h1) n_rst++;
    if (wd_enable_req === 1'h1) n_wd++;
    if (evt_valid === 1'h1 && evt_ready === 1'h1) n_pop++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    #1;
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic setmode(input int ch, input ltc_mode_t m);
    @(posedge core_clk);
    mode_wr <= 2'h1 << ch;
    mode_wr_data <= m;
    @(posedge core_clk);
    mode_wr <= 2'h0;
    step(2);
  endtask

  task automatic sys(input ltc_sys_t s);
    @(posedge core_clk);
    sys_mode <= s;
    step(3);
  endtask

  // Remote node holds its line dominant for len cycles, then releases
  task automatic wake(input int ch, input int len);
    @(posedge core_clk);
    remote_dom[ch] <= 1'h1;
    step(len);
    remote_dom[ch] <= 1'h0;
    step(3);
  endtask

  task automatic clr_all();
    @(posedge core_clk);
    int_clr <= 1'h1;
    wake_status_clr <= 2'h3;
    fail_clr <= 2'h3;
    @(posedge core_clk);
    int_clr <= 1'h0;
    wake_status_clr <= 2'h0;
    fail_clr <= 2'h0;
    step(1);
  endtask

  task automatic cfg(input ltc_cfg_t v);
    ltc_cfg_t prev;
    prev = slope_cfg;
    @(posedge core_clk);
    cfg_wr <= 1'h1;
    cfg_wr_data <= v;
    spi_chip_select_n <= 1'h0;
    @(posedge core_clk);
    cfg_wr <= 1'h0;
    step(2);
    chk("slope_early", 8'(prev), 8'(slope_cfg));
    spi_chip_select_n <= 1'h1;
    step(2);
  endtask

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1_000_000;
    miscompares++;
    close_out();
  end

  initial begin
    miscompares = 0; comparisons = 0; n_rst = 0; n_wd = 0; n_pop = 0; nev = 0;
    sys_rst = 1'h1; sys_mode = SYS_NORMAL; mode_wr = 2'h0; mode_wr_data = MODE_OFF;
    lin_tx_input = 2'h3; remote_dom = 2'h0; supply_uv = 1'h0; fail_clr = 2'h0;
    wake_status_clr = 2'h0; int_clr = 1'h0; watchdog_on_bus_wake = 1'h0;
    wd_enabled = 1'h0; cfg_wr = 1'h0; cfg_wr_data = CFG_RST;
    spi_chip_select_n = 1'h1; evt_ready = 1'h0;
    step(4);
    sys_rst <= 1'h0;
    step(1);
    chk("mode0", 8'(MODE_OFF), 8'(mode0));
    chk("rx_out", 8'h03, 8'(rx_out));
    chk("slope", 8'h00, 8'(slope_cfg));
    wake(0, 3010);
    chk("status_off", 8'h00, 8'(wsrc));
    chk("int_off", 8'h01, 8'(int_n));
    sys(SYS_SLEEP);
    setmode(0, MODE_NORM);
    chk("mode_sleep", 8'(MODE_OFF), 8'(mode0));
    sys(SYS_NORMAL);
    setmode(0, MODE_NORM);
    chk("mode_norm", 8'(MODE_NORM), 8'(mode0));
    lin_tx_input[0] <= 1'h0; // Early dominant on purpose
    step(1100);
    chk("drv_hold", 8'h00, 8'(drv));
    lin_tx_input[0] <= 1'h1; // Return recessive
    step(2);
    lin_tx_input[0] <= 1'h0;
    step(3);
    chk("drv_send", 8'h01, 8'(drv));
    chk("rx_dom", 8'h02, 8'(rx_out));
    step(55);
    chk("fail_txd", 8'h01, 8'(fail0));
    chk("drv_txd", 8'h00, 8'(drv));
    lin_tx_input[0] <= 1'h1;
    clr_all();
    lin_tx_input[0] <= 1'h0;
    step(3);
    chk("drv_back", 8'h01, 8'(drv));
    chk("mode_txd", 8'(MODE_NORM), 8'(mode0));
    lin_tx_input[0] <= 1'h1;
    setmode(1, MODE_RXO);
    remote_dom[1] <= 1'h1;
    step(3);
    chk("rx_rxo", 8'h01, 8'(rx_out));
    chk("drv_rxo", 8'h00, 8'(drv));
    step(55);
    chk("fail_bus", 8'h01, 8'(fail1));
    chk("mode_bus", 8'(MODE_RXO), 8'(mode1));
    supply_uv <= 1'h1;
    step(3);
    chk("rx_uv", 8'h03, 8'(rx_out));
    supply_uv <= 1'h0;
    step(3);
    chk("rx_uv_end", 8'h01, 8'(rx_out));
    chk("mode_uv", 8'(MODE_RXO), 8'(mode1));
    remote_dom[1] <= 1'h0;
    clr_all();
    setmode(0, MODE_WAKE);
    wake(0, 3010);
    nev++;
    chk("rx_wake", 8'h02, 8'(rx_out));
    chk("status_norm", 8'h01, 8'(wsrc));
    chk("int_norm", 8'h00, 8'(int_n));
    chk("mode_woken", 8'(MODE_WAKE), 8'(mode0));
    clr_all();
    wake(0, 3010);
    chk("status_unarmed", 8'h00, 8'(wsrc));
    setmode(0, MODE_OFF); // Toggle away and back to re-arm
    chk("rx_release", 8'h03, 8'(rx_out));
    setmode(0, MODE_WAKE);
    wake(0, 2900);
    chk("status_short", 8'h00, 8'(wsrc));
    wake(0, 3010);
    nev++;
    chk("status_rearm", 8'h01, 8'(wsrc));
    clr_all();
    sys(SYS_SLEEP);
    wake(0, 3010);
    nev++;
    chk("restart_sleep", 8'h01, 8'(n_rst));
    chk("int_sleep", 8'h01, 8'(int_n));
    chk("status_sleep", 8'h01, 8'(wsrc));
    clr_all();
    watchdog_on_bus_wake <= 1'h1;
    sys(SYS_STOP);
    wake(0, 3010);
    nev++;
    chk("wd_req", 8'h01, 8'(n_wd));
    chk("int_stop", 8'h00, 8'(int_n));
    clr_all();
    sys(SYS_FAILSAFE);
    chk("mode1_fs", 8'(MODE_WAKE), 8'(mode1));
    wake(1, 3010);
    nev++;
    chk("restart_fs", 8'h02, 8'(n_rst));
    chk("int_fs", 8'h01, 8'(int_n));
    chk("rx_fs", 8'h00, 8'(rx_out));
    cfg(2'h3);
    chk("slope_fs", 8'h00, 8'(slope_cfg));
    sys(SYS_NORMAL);
    cfg(2'h1);
    chk("slope_low", 8'h01, 8'(slope_cfg));
    cfg(2'h2);
    chk("slope_flash", 8'h02, 8'(slope_cfg));
    setmode(1, MODE_OFF);
    chk("mode1_off", 8'(MODE_OFF), 8'(mode1));
    chk("evt_held", 8'h01, 8'(evt_valid));
    chk("evt_head", 8'h21, 8'(evt_data));
    evt_ready <= 1'h1;
    for (int i = 0; i < 20 && evt_valid !== 1'h0; i++) step(1);
    step(1);
    chk("evt_pops", 8'(nev), 8'(n_pop));
    chk("evt_empty", 8'h00, 8'(evt_valid));
    close_out();
  end
endmodule

`default_nettype wire
